// ==== hw/burst_rom_area0.sv ====
/*
  Area-0 burst ROM (clock-asynchronous) timing control with its APB
  configuration register. Assumes a bus controller that requests 16-byte
  fills and a ROM whose wait pin arrives asynchronously.
*/
// Local design decisions: the APB interface to the registers and the address map.
// Operation
// RULE_01 - Long bursts on: one 8-beat (16-bit) or 16-beat (8-bit) burst.
// RULE_02 - Long bursts off: four 2-beat (16-bit) or 4-beat (8-bit) bursts.
// RULE_03 - The burst wait field adds 0 to 3 idle cycles before later beats.
// RULE_04 - The first-access field adds 0,1,2,3,4,5,6,8,10,12,14,18 cycles.
// RULE_05 - Software must not write codes 1101 to 1111 as first-access wait.
// RULE_06 - The external wait input is obeyed when the ignore bit is 0.
// RULE_07 - The ignore bit applies even with zero first-access waits.
// RULE_08 - Reserved bits read zero and writes to them are dropped.
// RULE_09 - First-access code 1100 gives 24 wait cycles.
`timescale 1ns/10ps
`include "burst_rom_defines.svh"
module burst_rom_area0
  import burst_rom_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fill_req,
  input  wire logic        bus_is_8bit,
  output logic             fill_busy,
  output logic             rom_strobe,
  output logic             beat_done,
  output logic             burst_start,
  output logic             fill_done,
  input  wire logic        ext_wait_n
);
  // ==========================================================
  // APB register
  logic [31:0] cfg_q;
  logic [31:0] prdata_q;
  wire         hit       = (paddr == `WCR_OFFSET);
  wire         acc       = psel & penable;
  wire         wr_en     = acc & pwrite & hit;
  wire [31:0]  cfg_d     = pwdata & `WCR_WRITE_MASK;          // [RULE_08]
  wire         long_burst_disable = cfg_q[`WCR_LBD_BIT];
  wire         burst_wait_count_hi = cfg_q[`WCR_BW_HI];
  wire         burst_wait_count_lo = cfg_q[`WCR_BW_LO];
  wire [3:0]   first_wait_code = cfg_q[`WCR_W_HI:`WCR_W_LO];
  wire         ext_wait_ignore = cfg_q[`WCR_IGN_BIT];
  wire [1:0]   bw_cycles = {burst_wait_count_hi, burst_wait_count_lo};

  assign pready  = 1'b1;
  // Unmapped addresses error so software notices a bad pointer
  assign pslverr = acc & ~hit;
  assign prdata  = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= `WCR_RESET;
    else if (wr_en)
      cfg_q <= cfg_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata_q <= hit ? cfg_q : 32'h0000_0000;                // [RULE_08]
  end

  // ==========================================================
  // Wait pin synchroniser
  logic wait_meta_q;
  logic wait_sync_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_meta_q <= 1'b1;
      wait_sync_q <= 1'b1;
    end
    else
    begin
      wait_meta_q <= ext_wait_n;
      wait_sync_q <= wait_meta_q;
    end
  end
  // Mask applies regardless of the first-access count
  wire ext_hold = ~wait_sync_q & ~ext_wait_ignore; // [RULE_06] [RULE_07]

  // ==========================================================
  // First-access wait decode
  logic [4:0] first_cycles;
  wait_decode u_decode
  (
    .code   (first_wait_code),
    .cycles (first_cycles)
  );

  // ==========================================================
  // Burst shape
  // Burst shape (long-burst disable, bus width) is latched per fill so a mid-fill write cannot tear it
  logic       disable_q;
  logic       bus8_q;
  wire  [4:0] beats_long  = bus8_q ? `BEATS_LONG_8 : `BEATS_LONG_16;
  wire  [4:0] beats_short = bus8_q ? `BEATS_SHORT_8 : `BEATS_SHORT_16;
  wire  [4:0] beats_per   = disable_q ? beats_short : beats_long; // [RULE_01]
  wire  [2:0] bursts_tot  = disable_q ? `SHORT_BURSTS : 3'h1;    // [RULE_02]

  // ==========================================================
  // Fill sequencer
  fill_state_type state_q;
  fill_state_type state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] beat_q;
  logic [4:0] beat_d;
  logic [2:0] burst_q;
  logic [2:0] burst_d;

  wire last_beat  = (beat_q == beats_per - 5'h01);
  wire last_burst = (burst_q == bursts_tot - 3'h1);
  wire cnt_zero   = (cnt_q == 5'h00);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    beat_d  = beat_q;
    burst_d = burst_q;
    case (state_q)
      ST_IDLE:
      begin
        if (fill_req)
        begin
          state_d = ST_FIRST;
          cnt_d   = first_cycles;                             // [RULE_04]
          beat_d  = 5'h00;
          burst_d = 3'h0;
        end
      end
      ST_FIRST:
      begin
        if (!cnt_zero)
          cnt_d = cnt_q - 5'h01;
        else
          state_d = ST_EWAIT;
      end
      ST_EWAIT:
      begin
        if (!ext_hold)                                        // [RULE_06]
          state_d = ST_BEAT;
      end
      ST_BEAT:
      begin
        if (last_beat)
        begin
          if (last_burst)
            state_d = ST_IDLE;
          else
          begin
            burst_d = burst_q + 3'h1;
            beat_d  = 5'h00;
            cnt_d   = first_cycles;
            state_d = ST_FIRST;
          end
        end
        else
        begin
          beat_d  = beat_q + 5'h01;
          cnt_d   = {3'b000, bw_cycles};                      // [RULE_03]
          state_d = ST_BWAIT;
        end
      end
      ST_BWAIT:
      begin
        if (!cnt_zero)
          cnt_d = cnt_q - 5'h01;                              // [RULE_03]
        else if (!ext_hold)
          state_d = ST_BEAT;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
      beat_q  <= 5'h00;
      burst_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      beat_q  <= beat_d;
      burst_q <= burst_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disable_q <= 1'b0;
      bus8_q    <= 1'b0;
    end
    else if (state_q == ST_IDLE && fill_req)
    begin
      disable_q <= long_burst_disable;
      bus8_q    <= bus_is_8bit;
    end
  end

  // ==========================================================
  // Strobes
  logic done_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_q <= 1'b0;
    else
      done_q <= (state_q == ST_BEAT) & last_beat & last_burst;
  end

  assign fill_busy   = (state_q != ST_IDLE);
  assign rom_strobe  = (state_q != ST_IDLE);
  assign beat_done   = (state_q == ST_BEAT);
  assign burst_start = (state_q == ST_FIRST) & (cnt_q == first_cycles)
                     & (beat_q == 5'h00);
  assign fill_done   = done_q;
endmodule

// ==== hw/burst_rom_defines.svh ====
/*
  Offsets, field positions, reset values and timing codes of the area-0
  burst ROM wait control. Assumes inclusion by bare name from hw/.
*/
`ifndef BURST_ROM_DEFINES_SVH
`define BURST_ROM_DEFINES_SVH

// ==========================================================
// Register map
`define WCR_OFFSET        12'h000
`define WCR_RESET         32'h0000_0500
// ==========================================================
// Field positions
`define WCR_LBD_BIT       20
`define WCR_BW_HI         17
`define WCR_BW_LO         16
`define WCR_W_HI          10
`define WCR_W_LO          7
`define WCR_IGN_BIT       6
`define WCR_WRITE_MASK    32'h0013_07C0
// ==========================================================
// Beats per burst and short-mode burst count of a 16-byte fill
`define BEATS_LONG_16     5'h08
`define BEATS_LONG_8      5'h10
`define BEATS_SHORT_16    5'h02
`define BEATS_SHORT_8     5'h04
`define SHORT_BURSTS      3'h4
// ==========================================================
// First-access wait code table
`define FW_CODE_24        4'hC
`define FW_CYC_24         5'h18

`endif

// ==== hw/burst_rom_pkg.sv ====
/*
  Types of the area-0 burst ROM timing block.
  Assumes nothing beyond the compile order.
*/
package burst_rom_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_FIRST = 3'b001,
    ST_BEAT  = 3'b010,
    ST_BWAIT = 3'b011,
    ST_EWAIT = 3'b100
  } fill_state_type;
endpackage

// ==== hw/wait_decode.sv ====
/*
  Decodes the four-bit first-access wait code into a cycle count.
  Assumes the code comes from the configuration register.
*/
`timescale 1ns/10ps
`include "burst_rom_defines.svh"
module wait_decode
  import burst_rom_pkg::*;
(
  input  wire logic [3:0] code,
  output logic      [4:0] cycles
);
  // ==========================================================
  // Table
  always_comb
  begin
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
        cycles = {1'b0, code};                       // [RULE_04]
      4'h7: cycles = 5'h08;                          // [RULE_04]
      4'h8: cycles = 5'h0A;
      4'h9: cycles = 5'h0C;
      4'hA: cycles = 5'h0E;
      4'hB: cycles = 5'h12;
      `FW_CODE_24: cycles = `FW_CYC_24;              // [RULE_09]
      // Prohibited codes: fall back to longest legal wait, safest
      default: cycles = `FW_CYC_24;                  // [RULE_05]
    endcase
  end
endmodule

// ==== bench/rom_model.sv ====
/*
  Slow or prompt burst ROM on area 0.
  Assumes the strobe is high for the whole fill.
*/
`timescale 1ns/10ps
module rom_model
(
  input  wire logic pclk,
  input  wire logic rom_strobe,
  input  wire logic slow,
  output logic      ext_wait_n
);
  int n = 0;
  // =====================================
  // Wait pin
  // When slow, held low before selection so the synchroniser sees it in time
  always @(posedge pclk)
    n <= rom_strobe ? n + 1 : 0;
  assign ext_wait_n = !(slow && n < 6);
endmodule

// ==== bench/burst_rom_area0_chk.sv ====
/*
  Port checks of the area-0 burst ROM timing block.
  Assumes binding into burst_rom_area0.
*/
`timescale 1ns/10ps
module burst_rom_area0_chk
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        fill_req,
  input  wire logic        fill_busy,
  input  wire logic        rom_strobe,
  input  wire logic        beat_done,
  input  wire logic        burst_start,
  input  wire logic        fill_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================
  // Assertions
  pready_high_a: assert property (pready)
    else $error("pready low");
  err_decode_a: assert property (psel && penable |->
    pslverr == (paddr != 12'h000)) else $error("bad pslverr");
  rsvd_zero_a: assert property ((prdata & 32'hFFEC_F83F) == 32'h0)
    else $error("reserved bits set");
  strobe_busy_a: assert property (rom_strobe == fill_busy)
    else $error("strobe differs from busy");
  fill_take_a: assert property (fill_req && !fill_busy |=>
    burst_start && fill_busy) else $error("fill not taken");
  busy_rise_a: assert property ($rose(fill_busy) |-> burst_start)
    else $error("fill without burst start");
  first_gap_a: assert property (burst_start |->
    !beat_done ##1 !beat_done) else $error("beat too soon");
  beat_gap_a: assert property (beat_done |=> !beat_done)
    else $error("beats adjacent");
  done_pulse_a: assert property (fill_done |->
    $past(beat_done) && !fill_busy && !beat_done) else $error("bad done");
  c_beat: cover property (beat_done);
  c_done: cover property (fill_done);
  c_err: cover property (pslverr);
endmodule
bind burst_rom_area0 burst_rom_area0_chk chk_inst(.pclk, .presetn, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .fill_req, .fill_busy,
  .rom_strobe, .beat_done, .burst_start, .fill_done);

// ==== bench/test_burst_rom_area0.sv ====
/*
  Self-checking bench of the area-0 burst ROM timing block.
  Assumes the ROM model and the checker are compiled first.
*/
`timescale 1ns/10ps
module test_burst_rom_area0 import burst_rom_pkg::*;;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        fill_req = 0, bus_is_8bit = 0, slow = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, mreg, wv;
  logic        pready, pslverr, fill_busy, rom_strobe, beat_done;
  logic        burst_start, fill_done, ext_wait_n;
  int failures = 0, samples_checked = 0, cyc = 0, nb, ns, ts, tb, lat, gap;
  int tbl[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
  initial forever #12.5 pclk = ~pclk;
  burst_rom_area0 burst_rom_area0_inst
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .fill_req    (fill_req),
    .bus_is_8bit (bus_is_8bit),
    .fill_busy   (fill_busy),
    .rom_strobe  (rom_strobe),
    .beat_done   (beat_done),
    .burst_start (burst_start),
    .fill_done   (fill_done),
    .ext_wait_n  (ext_wait_n)
  );
  rom_model rom_model_inst
  (
    .pclk       (pclk),
    .rom_strobe (rom_strobe),
    .slow       (slow),
    .ext_wait_n (ext_wait_n)
  );
  // =====================================
  // Monitor
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (burst_start && ns == 0) ts <= cyc;
    if (burst_start) ns <= ns + 1;
    if (beat_done && nb == 0) lat <= cyc - ts;
    if (beat_done && nb == 1) gap <= cyc - tb;
    if (beat_done) tb <= cyc;
    if (beat_done) nb <= nb + 1;
  end
  // =====================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == 12'h000) mreg = d & 32'h0013_07C0;
  endtask
  task fill(input logic [31:0] cfg, input logic e8);
    apb(1, 12'h000, cfg);
    nb = 0;
    ns = 0;
    bus_is_8bit <= e8;
    fill_req <= 1'b1;
    @(posedge pclk);
    fill_req <= 1'b0;
    // Negedge sampling lets the monitor's updates land first
    do @(negedge pclk); while (fill_done !== 1'b1);
    @(posedge pclk);
  endtask
  task final_report;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // =====================================
  // Tests
  initial
  begin
    void'($urandom(32'h61BF4525));
    mreg = 32'h0000_0500;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, mreg);
    repeat (3)
    begin
      wv = $urandom & 32'h0013_07C0;
      // Prohibited first-access codes fold back to legal ones
      if (wv[10:7] > 4'hC) wv[9] = 1'b0;
      apb(1, 12'h000, wv);
      apb(0, 12'h000, 0);
      chk(rd, mreg);
    end
    apb(1, 12'h004, 32'hFFFF_FFFF);
    chk(err, 1);
    apb(0, 12'h000, 0);
    chk(rd, mreg);
    $display("register test done");
    // Codes above 1100 are never written
    for (int c = 0; c < 13; c++)
    begin
      fill({21'h0, 4'(c), 7'h40}, $urandom);
      chk(lat, 2 + tbl[c]);
    end
    for (int b = 0; b < 4; b++)
    begin
      fill({14'h0, 2'(b), 16'h0040}, 0);
      chk(gap, 2 + b);
    end
    for (int m = 0; m < 4; m++)
    begin
      fill({11'h0, 1'(m >> 1), 20'h40}, 1'(m));
      chk(nb, m[0] ? 16 : 8);
      chk(ns, m[1] ? 4 : 1);
    end
    $display("fill test done");
    slow <= 1'b1;
    fill(32'h40, 0);
    chk(lat, 2);
    fill(32'h0, 0);
    chk(lat > 2, 1);
    slow <= 1'b0;
    $display("wait test done");
    final_report;
  end
  initial
  begin
    #500000;
    failures++;
    final_report;
  end
endmodule
